/* smbc_pkg.sv */
// package for the stacked memory bus control block
package smbc_pkg;
	localparam int FLASH_DIES = 3;
	localparam int PSRAM_DIES = 2;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int WAIT_POL_BIT = 10;
	localparam int CFG_W = 16;
	localparam logic [15:0] CFG_RESET = 16'h0400;
	localparam int INIT_LATENCY = 3;
	localparam logic [3:0] LAT_RESET = 4'h3;
	localparam logic [23:0] ADDR_RESET = 24'h000000;

	typedef enum {SMBC_IDLE, SMBC_SYNC_WAIT, SMBC_SYNC_DATA, SMBC_ASYNC, SMBC_WRITE} smbc_mode_e;

	// host strobes, active low unless named high
	typedef struct packed {
		logic [2:0] flashCeN;
		logic [1:0] flashOeN;
		logic flashWeN;
		logic addressValidStrobeN;
		logic sramSelectLow;
		logic sramSelectHigh;
		logic [1:0] psramCsN;
		logic ramOeN;
		logic ramWeN;
	} smbc_ctrl_s;

	// per-die enables seen by the array side
	typedef struct packed {
		logic [2:0] flashActive;
		logic [2:0] flashDrive;
		logic sramActive;
		logic [1:0] psramActive;
		logic ramDrive;
		logic ramWrite;
	} smbc_status_s;
endpackage : smbc_pkg

/* smbc_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module smbc_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_dout;

	always_comb begin
		next_stage1 = din;
		next_dout = stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage1 <= INIT;
			dout <= INIT;
		end else begin
			stage1 <= next_stage1;
			dout <= next_dout;
		end
	end
endmodule : smbc_sync2
`default_nettype wire

/* smbc_ctrl.sv */
// die select, output enable, write strobe, address latch and wait logic
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - sram active only when both selects asserted
// - each psram die has own low select
// - flash drives data only while output enable low
// - enable one: die one; two: dies two, three
// - ram drives outputs only while ram enable low
// - flash write captured on write strobe rising edge
// - separate ram write strobe, independent of flash
// - synchronous burst counter advances on bus clock
// - sync address latched at strobe rise or clock
// - async address latched at rise, else flows
// - wait polarity follows configuration bit ten
// - wait floats when flash chip enable high
// - sync read: wait asserted while data invalid
// - async page reads, writes hold wait asserted
// - low chip enable selects die, else standby
module smbc_ctrl
	import smbc_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// host pins
	input wire smbc_pkg::smbc_ctrl_s ctrlPins,
	input wire logic busClock,
	input wire logic [AW-1:0] addressPins,
	input wire logic [DW-1:0] dataIn,
	// flash configuration
	input wire logic [smbc_pkg::CFG_W-1:0] read_configuration_register,
	input wire logic syncReadMode,
	input wire logic [3:0] latencyCycles,
	input wire logic [DW-1:0] arrayData,
	// outputs
	output logic [DW-1:0] dataOut,
	output logic dataOe,
	output logic waitOut,
	output logic waitOe,
	output logic [AW-1:0] flashAddress,
	output logic [AW-1:0] writeAddress,
	output logic [DW-1:0] writeData,
	output logic flashWritePulse,
	output logic ramWritePulse,
	output smbc_pkg::smbc_status_s status
);
	import smbc_pkg::*;

	localparam int CW = $bits(smbc_ctrl_s);
	localparam logic [CW-1:0] CTRL_IDLE = {3'h7, 2'h3, 1'h1, 1'h1, 1'h1, 1'h0, 2'h3, 1'h1, 1'h1};

	smbc_ctrl_s pins;
	logic [CW-1:0] pinsRaw;
	logic clkS;
	logic [AW-1:0] addrS;
	logic [DW-1:0] dataS;

	// pins come from the host's timing domain
	smbc_sync2 #(.W(CW), .INIT(CTRL_IDLE)) u_sync_ctrl (
		.clk_sys(clk_sys),
		.reset(reset),
		.din(ctrlPins),
		.dout(pinsRaw)
	);
	smbc_sync2 #(.W(1), .INIT(1'h0)) u_sync_clk (
		.clk_sys(clk_sys),
		.reset(reset),
		.din(busClock),
		.dout(clkS)
	);
	smbc_sync2 #(.W(AW + DW), .INIT('0)) u_sync_ad (
		.clk_sys(clk_sys),
		.reset(reset),
		.din({addressPins, dataIn}),
		.dout({addrS, dataS})
	);
	assign pins = smbc_ctrl_s'(pinsRaw);

	// edge history
	logic clkPrev, strobePrev, fWePrev, rWePrev;
	logic clkRise, strobeRise, fWeRise, rWeRise;
	logic anyFlashSel;
	smbc_mode_e mode, next_mode;
	logic [3:0] latCount, next_latCount;
	logic [AW-1:0] next_flashAddress, next_writeAddress;
	logic [DW-1:0] next_writeData, next_dataOut;
	logic addrLatched, next_addrLatched;
	logic waitAsserted;
	logic waitPol;

	assign clkRise = clkS & ~clkPrev;
	assign strobeRise = pins.addressValidStrobeN & ~strobePrev;
	assign fWeRise = pins.flashWeN & ~fWePrev;
	assign rWeRise = pins.ramWeN & ~rWePrev;
	assign anyFlashSel = ~&pins.flashCeN;

	// die activity and output drive
	always_comb begin
		status.flashActive = ~pins.flashCeN;
		status.flashDrive[0] = ~pins.flashCeN[0] & ~pins.flashOeN[0];
		status.flashDrive[1] = ~pins.flashCeN[1] & ~pins.flashOeN[1];
		status.flashDrive[2] = ~pins.flashCeN[2] & ~pins.flashOeN[1];
		status.sramActive = ~pins.sramSelectLow & pins.sramSelectHigh;
		status.psramActive = ~pins.psramCsN;
		status.ramDrive = (status.sramActive | (|status.psramActive)) & ~pins.ramOeN;
		status.ramWrite = (status.sramActive | (|status.psramActive)) & ~pins.ramWeN;
	end

	// flash drives data whenever a die's enable pair is low, in any mode; ram data path lies outside
	assign dataOe = |status.flashDrive;
	assign waitPol = read_configuration_register[WAIT_POL_BIT];
	assign waitOe = anyFlashSel;

	always_comb begin
		waitAsserted = 1'b1;
		if (mode == SMBC_SYNC_DATA) begin
			waitAsserted = 1'b0;
		end
		waitOut = waitAsserted ? waitPol : ~waitPol;
	end

	always_comb begin
		next_mode = mode;
		next_latCount = latCount;
		next_flashAddress = flashAddress;
		next_addrLatched = addrLatched;
		next_writeAddress = writeAddress;
		next_writeData = writeData;
		next_dataOut = dataOut;
		if (!anyFlashSel) begin
			next_mode = SMBC_IDLE;
			next_addrLatched = 1'b0;
		end else if (!pins.flashWeN || fWeRise) begin
			next_mode = SMBC_WRITE;
		end else if (syncReadMode) begin
			if (!addrLatched && (strobeRise || (clkRise && !pins.addressValidStrobeN))) begin
				next_flashAddress = addrS;
				next_addrLatched = 1'b1;
				next_latCount = latencyCycles;
				next_mode = SMBC_SYNC_WAIT;
			end else if (!pins.addressValidStrobeN && addrLatched && strobePrev) begin
				// new address cycle: old burst word is not valid for it
				next_addrLatched = 1'b0;
				next_mode = SMBC_SYNC_WAIT;
			end else if (clkRise) begin
				if (mode == SMBC_SYNC_WAIT) begin
					if (latCount <= 4'h1) begin
						next_mode = SMBC_SYNC_DATA;
						next_dataOut = arrayData;
					end else begin
						next_latCount = latCount - 4'h1;
					end
				end else if (mode == SMBC_SYNC_DATA) begin
					next_flashAddress = flashAddress + AW'(1);
					next_dataOut = arrayData;
				end
			end
		end else begin
			next_mode = SMBC_ASYNC;
			if (!pins.addressValidStrobeN || strobeRise) begin
				next_flashAddress = addrS;
			end
			next_dataOut = arrayData;
		end
		if (fWeRise) begin
			next_writeAddress = addrS;
			next_writeData = dataS;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mode <= SMBC_IDLE;
			latCount <= LAT_RESET;
			flashAddress <= ADDR_RESET;
			writeAddress <= ADDR_RESET;
			writeData <= '0;
			dataOut <= '0;
			addrLatched <= 1'b0;
			clkPrev <= 1'b0;
			strobePrev <= 1'b1;
			fWePrev <= 1'b1;
			rWePrev <= 1'b1;
			flashWritePulse <= 1'b0;
			ramWritePulse <= 1'b0;
		end else begin
			mode <= next_mode;
			latCount <= next_latCount;
			flashAddress <= next_flashAddress;
			writeAddress <= next_writeAddress;
			writeData <= next_writeData;
			dataOut <= next_dataOut;
			addrLatched <= next_addrLatched;
			clkPrev <= clkS;
			strobePrev <= pins.addressValidStrobeN;
			fWePrev <= pins.flashWeN;
			rWePrev <= pins.ramWeN;
			flashWritePulse <= fWeRise & anyFlashSel;
			ramWritePulse <= rWeRise & (status.sramActive | (|status.psramActive));
		end
	end

	chk_wait_float: assert property (@(posedge clk_sys) disable iff (reset)
		&pins.flashCeN |-> !waitOe) else $error("wait driven while deselected");
	chk_wait_polarity: assert property (@(posedge clk_sys) disable iff (reset)
		(mode == SMBC_WRITE) |-> (waitOut == waitPol)) else $error("wait not asserted in write");
	chk_sync_valid: assert property (@(posedge clk_sys) disable iff (reset)
		(mode == SMBC_SYNC_DATA) |-> (waitOut == ~waitPol)) else $error("wait asserted on valid data");
	chk_async_wait: assert property (@(posedge clk_sys) disable iff (reset)
		(mode == SMBC_ASYNC) |-> (waitOut == waitPol)) else $error("wait not asserted in async");
	chk_flash_oe: assert property (@(posedge clk_sys) disable iff (reset)
		pins.flashOeN[1] |-> !status.flashDrive[1] && !status.flashDrive[2]) else $error("dies two three drive");
	chk_flash_drive: assert property (@(posedge clk_sys) disable iff (reset)
		&pins.flashOeN |-> !dataOe) else $error("flash drives with enables high");
	chk_sram_select: assert property (@(posedge clk_sys) disable iff (reset)
		status.sramActive |-> !pins.sramSelectLow && pins.sramSelectHigh) else $error("sram active wrongly");
	chk_psram_select: assert property (@(posedge clk_sys) disable iff (reset)
		status.psramActive == ~pins.psramCsN) else $error("psram select mismatch");
	chk_ram_oe: assert property (@(posedge clk_sys) disable iff (reset)
		pins.ramOeN |-> !status.ramDrive) else $error("ram drives with enable high");
	chk_write_capture: assert property (@(posedge clk_sys) disable iff (reset)
		fWeRise |=> (writeAddress == $past(addrS)) && (writeData == $past(dataS))) else $error("write not captured");
	chk_ram_write: assert property (@(posedge clk_sys) disable iff (reset)
		rWeRise && status.ramWrite == 1'b0 && !status.sramActive && status.psramActive == 2'h0 |=> !ramWritePulse) else $error("ram write while deselected");
	chk_burst_step: assert property (@(posedge clk_sys) disable iff (reset)
		(mode == SMBC_SYNC_DATA) && (next_mode == SMBC_SYNC_DATA) && clkRise && syncReadMode
		&& addrLatched && pins.addressValidStrobeN && pins.flashWeN && !fWeRise
		|=> flashAddress == $past(flashAddress) + AW'(1)) else $error("burst address not advanced");
	chk_async_flow: assert property (@(posedge clk_sys) disable iff (reset)
		anyFlashSel && !syncReadMode && pins.flashWeN && !fWeRise && !pins.addressValidStrobeN |=> flashAddress == $past(addrS)) else $error("address not flowing");

	cov_sync_burst: cover property (@(posedge clk_sys) mode == SMBC_SYNC_WAIT ##[1:40] mode == SMBC_SYNC_DATA);
	cov_flash_write: cover property (@(posedge clk_sys) flashWritePulse);
	cov_ram_write: cover property (@(posedge clk_sys) ramWritePulse);
	cov_async_read: cover property (@(posedge clk_sys) mode == SMBC_ASYNC && dataOe);
endmodule : smbc_ctrl
`default_nettype wire

/* smbc_host_model.sv */
// host-side bus model driving the stacked memory pins
`timescale 1ns/1ns
`default_nettype none
module smbc_host_model
	import smbc_pkg::*;
#(
	parameter int PSRAM_FITTED = 2
) (
	// clock
	input wire logic clk_sys,
	// host pins
	output smbc_pkg::smbc_ctrl_s ctrlPins,
	output logic busClock,
	output logic [23:0] addressPins,
	output logic [15:0] dataIn
);
	import smbc_pkg::*;
	// all strobes idle; bus clock stands still outside bursts
	initial begin
		ctrlPins = 13'h1fef;
		busClock = 1'b0;
		addressPins = 24'h000000;
		dataIn = 16'h0000;
	end
	// levels held three cycles so the two-flop input path always sees them
	task automatic drive(input smbc_ctrl_s c, input logic [23:0] a, input logic [15:0] d);
		if (!c.ramOeN) c.flashOeN = 2'h3;
		if (PSRAM_FITTED < 2) c.psramCsN[1] = 1'b1;
		@(posedge clk_sys);
		ctrlPins <= c;
		addressPins <= a;
		dataIn <= d;
		repeat (3) @(posedge clk_sys);
	endtask : drive
	task automatic busRise;
		@(posedge clk_sys);
		busClock <= 1'b1;
		repeat (3) @(posedge clk_sys);
		busClock <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : busRise
endmodule : smbc_host_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the stacked memory bus control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import smbc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [15:0] readCfg = 16'h0400;
	logic syncMode = 1'b0;
	logic [3:0] lat = 4'h2;
	logic [15:0] arrayData = 16'h0000;
	smbc_ctrl_s ctrlPins, c;
	smbc_status_s status;
	logic busClock, dataOe, waitOut, waitOe, fwp, rwp, pol;
	logic [23:0] addressPins, flashAddress, writeAddress, a, b;
	logic [15:0] dataIn, dataOut, writeData, dw;
	logic [31:0] r;
	int seed = 32'h4038;
	int badCount = 0;
	int nChecks = 0;
	int fwCnt = 0;
	int rwCnt = 0;
	int n, m;
	smbc_host_model host (.clk_sys(clk_sys), .ctrlPins(ctrlPins), .busClock(busClock),
		.addressPins(addressPins), .dataIn(dataIn));
	smbc_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .ctrlPins(ctrlPins), .busClock(busClock),
		.addressPins(addressPins), .dataIn(dataIn), .read_configuration_register(readCfg),
		.syncReadMode(syncMode), .latencyCycles(lat), .arrayData(arrayData),
		.dataOut(dataOut), .dataOe(dataOe), .waitOut(waitOut), .waitOe(waitOe),
		.flashAddress(flashAddress), .writeAddress(writeAddress), .writeData(writeData),
		.flashWritePulse(fwp), .ramWritePulse(rwp), .status(status));
	initial forever #20 clk_sys = ~clk_sys;
	// array model answers the current read address; pulses are counted, not timed
	always @(posedge clk_sys) begin
		arrayData <= ~flashAddress[15:0];
		if (fwp === 1'b1) fwCnt++;
		if (rwp === 1'b1) rwCnt++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic go(input logic [15:0] d);
		host.drive(c, a, d);
		#1;
	endtask : go
	task automatic summarize;
		if (badCount == 0 && nChecks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge clk_sys);
		badCount++;
		summarize();
	end
	initial begin
		c = 13'h1fef;
		a = 24'h000000;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check(status, 0);
		check({waitOe, dataOe}, 0);
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			c = r[12:0];
			c.flashWeN = 1'b1;
			c.ramWeN = 1'b1;
			c.addressValidStrobeN = 1'b1;
			if (!c.ramOeN) c.flashOeN = 2'h3;
			go(16'h0000);
			check(status.sramActive, !c.sramSelectLow && c.sramSelectHigh);
			check(status.psramActive, 2'(~c.psramCsN));
			check(status.flashActive, 3'(~c.flashCeN));
			check(status.flashDrive, 3'(~(c.flashCeN | {c.flashOeN[1], c.flashOeN})));
			check(dataOe, ~&(c.flashCeN | {c.flashOeN[1], c.flashOeN}));
			check(status.ramDrive, !c.ramOeN && ((!c.sramSelectLow && c.sramSelectHigh)
				|| !(&c.psramCsN)));
			check(waitOe, ~&c.flashCeN);
		end
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			@(posedge clk_sys);
			readCfg <= {5'h00, pol, 10'h000};
			syncMode <= 1'b0;
			c = 13'h1fef;
			c.flashCeN = 3'h6;
			r = $random(seed);
			a = r[23:0];
			dw = r[31:16];
			n = fwCnt;
			c.flashWeN = 1'b0;
			go(dw);
			check(waitOut, pol);
			c.flashWeN = 1'b1;
			go(dw);
			go(dw);
			check(fwCnt - n, 1);
			check(writeAddress, a);
			check(writeData, dw);
			// ram deselected on the first pass must refuse the strobe, selected on the second must take it
			c.flashCeN = 3'h7;
			c.sramSelectLow = 1'b0;
			c.sramSelectHigh = pol;
			n = rwCnt;
			m = fwCnt;
			c.ramWeN = 1'b0;
			go(dw);
			check(status.ramWrite, p);
			c.ramWeN = 1'b1;
			go(dw);
			go(dw);
			check(rwCnt - n, p);
			check(fwCnt - m, 0);
			c = 13'h1fef;
			c.flashCeN = 3'h6;
			c.flashOeN = 2'h2;
			c.addressValidStrobeN = 1'b0;
			for (int k = 0; k < 2; k++) begin
				r = $random(seed);
				a = r[23:0];
				go(16'h0000);
				check(flashAddress, a);
			end
			b = a;
			c.addressValidStrobeN = 1'b1;
			go(16'h0000);
			a = ~b;
			go(16'h0000);
			check(flashAddress, b);
			check({waitOut, dataOe}, {pol, 1'b1});
			for (int v = 0; v < 2; v++) begin
				@(posedge clk_sys);
				syncMode <= 1'b1;
				lat <= 4'(2 + v);
				c.addressValidStrobeN = 1'b0;
				r = $random(seed);
				a = r[23:0];
				b = a;
				go(16'h0000);
				if (v == 0) host.busRise();
				// address held across the strobe rise, changed only afterwards
				c.addressValidStrobeN = 1'b1;
				go(16'h0000);
				a = ~b;
				go(16'h0000);
				check(flashAddress, b);
				check(waitOut, pol);
				n = 0;
				while (waitOut !== ~pol && n < 9) begin
					host.busRise();
					#1;
					n++;
				end
				check(n, 2 + v);
				check(dataOut, 16'(~b[15:0]));
				host.busRise();
				#1;
				check(flashAddress, 24'(b + 24'h000001));
			end
		end
		c = 13'h1fef;
		go(16'h0000);
		check(waitOe, 0);
		check(status, 0);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
